/* ums_pkg.sv */
// Constants shared by the master-mode serial port block.
// Assumes a 32-bit APB host; registers sit on aligned words.
package ums_pkg;
    localparam logic [7:0] UMS_ADDR_DATA = 8'h00;
    localparam logic [7:0] UMS_ADDR_STATUS = 8'h04;
    localparam logic [7:0] UMS_ADDR_CTRL_B = 8'h08;
    localparam logic [7:0] UMS_ADDR_CTRL_C = 8'h0c;
    localparam logic [7:0] UMS_ADDR_BAUD = 8'h10;
    // Status field positions
    localparam int UMS_RXC_BIT = 7;
    localparam int UMS_TXC_BIT = 6;
    localparam int UMS_UDRE_BIT = 5;
    // Interrupt and enable control field positions
    localparam int UMS_RXCIE_BIT = 7;
    localparam int UMS_TXCIE_BIT = 6;
    localparam int UMS_BUFFER_EMPTY_IRQ_ENABLE_BIT = 5;
    localparam int UMS_RXEN_BIT = 4;
    localparam int UMS_TXEN_BIT = 3;
    // Mode and format control field positions
    localparam int UMS_MODE_HI_BIT = 7;
    localparam int UMS_MODE_LO_BIT = 6;
    localparam int UMS_ORDER_BIT = 2;
    localparam int UMS_PHASE_BIT = 1;
    localparam int UMS_POL_BIT = 0;
    localparam logic [1:0] UMS_MODE_ASYNC = 2'h0;
    localparam logic [1:0] UMS_MODE_SYNC = 2'h1;
    localparam logic [1:0] UMS_MODE_SPI = 2'h3;
    // Reset values
    localparam logic [7:0] UMS_CTRL_B_RESET = 8'h00;
    localparam logic [7:0] UMS_CTRL_C_RESET = 8'h06;
    localparam logic [7:0] UMS_CTRL_C_WMASK = 8'hc7;
    localparam logic [11:0] UMS_BAUD_RESET = 12'h000;
    // Frame timing: eight bits, two clock edges per bit
    localparam logic [3:0] UMS_LAST_EDGE = 4'hf;
    localparam logic [1:0] UMS_RX_DEPTH = 2'h2;
endpackage : ums_pkg

/* ums_shifter.sv */
// Shift engine: one eight-bit frame per start pulse, clock made here.
// Assumes start only while busy is low and a steady divider per frame.
`timescale 1ns/1ns
`default_nettype none
module ums_shifter
    import ums_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb_first,
    input wire logic [11:0] divider,
    input wire logic miso,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte,
    output logic sck,
    output logic mosi
);
    logic [11:0] div_cnt_reg;
    logic [3:0] edge_reg;
    logic [3:0] edge_next;
    logic [7:0] tx_sh_reg;
    logic edge_tick;

    function automatic logic [2:0] bit_pos(input logic [2:0] idx, input logic lsb);
        bit_pos = lsb ? idx : 3'h7 - idx;
    endfunction : bit_pos

    // Half period is divider plus one system clocks
    assign edge_tick = busy & (div_cnt_reg == divider);
    assign edge_next = edge_reg + 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            div_cnt_reg <= 12'h000;
            edge_reg <= 4'h0;
        end else if (start) begin
            busy <= 1'b1;
            div_cnt_reg <= 12'h000;
            edge_reg <= 4'h0;
        end else if (edge_tick) begin
            div_cnt_reg <= 12'h000;
            edge_reg <= edge_next;
            if (edge_reg == UMS_LAST_EDGE) begin
                busy <= 1'b0;
            end
        end else if (busy) begin
            div_cnt_reg <= div_cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else begin
            done <= edge_tick & (edge_reg == UMS_LAST_EDGE);
        end
    end

    // Clock rests at its polarity level outside frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck <= 1'b0;
        end else if (!busy || start) begin
            sck <= cpol;
        end else if (edge_tick) begin
            sck <= ~sck;
        end
    end

    // Data changes on the edge that does not sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh_reg <= 8'h00;
            mosi <= 1'b1;
        end else if (start) begin
            tx_sh_reg <= tx_byte;
            mosi <= cpha ? 1'b1 : tx_byte[bit_pos(3'h0, lsb_first)];
        end else if (edge_tick && (edge_reg[0] != cpha) && edge_reg != UMS_LAST_EDGE) begin
            mosi <= tx_sh_reg[bit_pos(edge_next[3:1], lsb_first)];
        end else if (!busy) begin
            mosi <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_byte <= 8'h00;
        end else if (edge_tick && (edge_reg[0] == cpha)) begin
            rx_byte[bit_pos(edge_reg[3:1], lsb_first)] <= miso;
        end
    end

    sck_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!busy && !start) |=> (sck == $past(cpol)))
        else $error("serial clock not idle between frames");
endmodule : ums_shifter
`default_nettype wire

/* ums_core.sv */
// Master-only serial port in SPI mode with APB register access.
// Assumes a zero-glitch pclk; serial input pin is asynchronous.
`timescale 1ns/1ns
`default_nettype none
module ums_core
    import ums_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_irq_enable,
    input wire logic tx_complete_irq_taken,
    output logic rx_complete_irq,
    output logic tx_complete_irq,
    output logic buffer_empty_irq,
    output logic serial_clock_pin,
    output logic serial_clock_pin_oe,
    output logic serial_data_out_pin,
    output logic serial_data_out_pin_oe,
    input wire logic serial_data_in_pin,
    output logic serial_data_in_owned
);
    logic [7:0] ctrl_b_reg;
    logic [7:0] ctrl_c_reg;
    logic [11:0] baud_reg;
    logic [7:0] tx_buf_reg;
    logic tx_buf_full_reg;
    logic tx_active_reg;
    logic txc_reg;
    logic [7:0] rx_mem [0:1];
    logic [1:0] rx_count_reg;
    logic rx_wr_ptr_reg;
    logic rx_rd_ptr_reg;
    logic [2:0] din_sync_reg;
    logic din_stable_reg;
    logic access;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic spi_mode;
    logic rxen;
    logic start;
    logic busy;
    logic done;
    logic [7:0] rx_byte;
    logic rx_push;
    logic rx_pop;
    logic txc_clear;
    logic [7:0] status_val;
    logic [31:0] read_val;

    // Zero-wait slave would need combinational data, so answer a cycle late
    assign access = psel & penable & pready;
    assign wr_en = access & pwrite;
    assign rd_en = access & ~pwrite;
    assign mapped = (paddr == UMS_ADDR_DATA) || (paddr == UMS_ADDR_STATUS)
        || (paddr == UMS_ADDR_CTRL_B) || (paddr == UMS_ADDR_CTRL_C)
        || (paddr == UMS_ADDR_BAUD);

    assign spi_mode = ({ctrl_c_reg[UMS_MODE_HI_BIT], ctrl_c_reg[UMS_MODE_LO_BIT]}
        == UMS_MODE_SPI);
    assign rxen = ctrl_b_reg[UMS_RXEN_BIT];

    // Frame starts once a byte waits and the shifter is free
    assign start = tx_buf_full_reg & ~busy & tx_active_reg & spi_mode;

    // Error flags, collision flag and double speed do not exist here
    assign status_val = {(rx_count_reg != 2'h0), txc_reg, ~tx_buf_full_reg,
        5'h00};

    always_comb begin
        read_val = 32'h0000_0000;
        unique case (paddr)
            UMS_ADDR_DATA: read_val = {24'h000000, rx_mem[rx_rd_ptr_reg]};
            UMS_ADDR_STATUS: read_val = {24'h000000, status_val};
            UMS_ADDR_CTRL_B: read_val = {24'h000000, ctrl_b_reg[7:3], 3'h0};
            UMS_ADDR_CTRL_C: read_val = {24'h000000, ctrl_c_reg};
            UMS_ADDR_BAUD: read_val = {20'h00000, baud_reg};
            default: read_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            prdata <= read_val;
            pslverr <= psel & penable & ~pready & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_b_reg <= UMS_CTRL_B_RESET;
        end else if (wr_en && paddr == UMS_ADDR_CTRL_B) begin
            ctrl_b_reg <= {pwdata[7:3], 3'h0};
        end
    end

    // Mode and format land together in one write; 5:3 never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_c_reg <= UMS_CTRL_C_RESET;
        end else if (wr_en && paddr == UMS_ADDR_CTRL_C) begin
            ctrl_c_reg <= pwdata[7:0] & UMS_CTRL_C_WMASK;
        end
    end

    // Faster clock only by a smaller divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_reg <= UMS_BAUD_RESET;
        end else if (wr_en && paddr == UMS_ADDR_BAUD) begin
            baud_reg <= pwdata[11:0];
        end
    end

    // Disable takes hold only after buffer and shifter drain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_active_reg <= 1'b0;
        end else if (ctrl_b_reg[UMS_TXEN_BIT]) begin
            tx_active_reg <= 1'b1;
        end else if (!busy && !tx_buf_full_reg && !start) begin
            tx_active_reg <= 1'b0;
        end
    end

    // Writes while the buffer is full, the sender is disabled or the mode is not SPI are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_reg <= 8'h00;
            tx_buf_full_reg <= 1'b0;
        end else if (wr_en && paddr == UMS_ADDR_DATA && !tx_buf_full_reg
                     && tx_active_reg && spi_mode) begin
            tx_buf_reg <= pwdata[7:0];
            tx_buf_full_reg <= 1'b1;
        end else if (start) begin
            tx_buf_full_reg <= 1'b0;
        end
    end

    assign txc_clear = tx_complete_irq_taken
        | (wr_en && paddr == UMS_ADDR_STATUS && pwdata[UMS_TXC_BIT]);

    // A new completion wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txc_reg <= 1'b0;
        end else if (done && !tx_buf_full_reg) begin
            txc_reg <= 1'b1;
        end else if (txc_clear) begin
            txc_reg <= 1'b0;
        end
    end

    // Three-stage capture, four cycles of lag: receive needs divider >= 4
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_sync_reg <= 3'h7;
            din_stable_reg <= 1'b1;
        end else begin
            din_sync_reg <= {din_sync_reg[1:0], serial_data_in_pin};
            if (din_sync_reg[1] == din_sync_reg[2]) begin
                din_stable_reg <= din_sync_reg[2];
            end
        end
    end

    assign rx_push = done & rxen & (rx_count_reg != UMS_RX_DEPTH);
    assign rx_pop = rd_en & (paddr == UMS_ADDR_DATA) & (rx_count_reg != 2'h0);

    // Full buffer keeps the older bytes, the newest frame is lost
    always_ff @(posedge pclk) begin
        if (rx_push) begin
            rx_mem[rx_wr_ptr_reg] <= rx_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_count_reg <= 2'h0;
            rx_wr_ptr_reg <= 1'b0;
            rx_rd_ptr_reg <= 1'b0;
        end else if (!rxen) begin
            rx_count_reg <= 2'h0;
            rx_wr_ptr_reg <= 1'b0;
            rx_rd_ptr_reg <= 1'b0;
        end else begin
            if (rx_push) begin
                rx_wr_ptr_reg <= ~rx_wr_ptr_reg;
            end
            if (rx_pop) begin
                rx_rd_ptr_reg <= ~rx_rd_ptr_reg;
            end
            rx_count_reg <= rx_count_reg + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    // Interrupt lines gated by own enable and the global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_complete_irq <= 1'b0;
            tx_complete_irq <= 1'b0;
            buffer_empty_irq <= 1'b0;
        end else begin
            rx_complete_irq <= ctrl_b_reg[UMS_RXCIE_BIT] & global_irq_enable
                & (rx_count_reg != 2'h0);
            tx_complete_irq <= ctrl_b_reg[UMS_TXCIE_BIT] & global_irq_enable
                & txc_reg;
            buffer_empty_irq <= ctrl_b_reg[UMS_BUFFER_EMPTY_IRQ_ENABLE_BIT] & global_irq_enable
                & ~tx_buf_full_reg;
        end
    end

    // Pin ownership; clock pin has no input role and is always driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_clock_pin_oe <= 1'b1;
            serial_data_out_pin_oe <= 1'b0;
            serial_data_in_owned <= 1'b0;
        end else begin
            serial_clock_pin_oe <= 1'b1;
            serial_data_out_pin_oe <= tx_active_reg;
            serial_data_in_owned <= rxen;
        end
    end

    ums_shifter u_shifter (
        .pclk(pclk),
        .presetn(presetn),
        .start(start),
        .tx_byte(tx_buf_reg),
        .cpol(ctrl_c_reg[UMS_POL_BIT]),
        .cpha(ctrl_c_reg[UMS_PHASE_BIT]),
        .lsb_first(ctrl_c_reg[UMS_ORDER_BIT]),
        .divider(baud_reg),
        .miso(din_stable_reg),
        .busy(busy),
        .done(done),
        .rx_byte(rx_byte),
        .sck(serial_clock_pin),
        .mosi(serial_data_out_pin)
    );

    buf_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == UMS_ADDR_DATA && !tx_buf_full_reg && tx_active_reg
         && spi_mode) |=> (status_val[UMS_UDRE_BIT] == 1'b0))
        else $error("empty flag stayed set after data write");

    rx_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(rxen) |=> (rx_count_reg == 2'h0) && !status_val[UMS_RXC_BIT])
        else $error("receive buffer not flushed on disable");

    txc_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !tx_buf_full_reg) |=> txc_reg)
        else $error("transmit complete not set");

    rx_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_complete_irq |-> $past(ctrl_b_reg[UMS_RXCIE_BIT] && global_irq_enable
            && rx_count_reg != 2'h0))
        else $error("receive interrupt without cause");

    tx_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_b_reg[UMS_TXCIE_BIT] && global_irq_enable && txc_reg)
        |=> tx_complete_irq)
        else $error("transmit interrupt missing");

    empty_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        buffer_empty_irq |-> $past(ctrl_b_reg[UMS_BUFFER_EMPTY_IRQ_ENABLE_BIT] && global_irq_enable
            && !tx_buf_full_reg))
        else $error("empty interrupt without cause");

    tx_defer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_active_reg && (busy || tx_buf_full_reg)) |=> tx_active_reg)
        else $error("transmitter released with data pending");

    ctrl_c_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_c_reg[5:3] == 3'h0)
        else $error("read-only format bits changed");

    overflow_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && rxen && rx_count_reg == UMS_RX_DEPTH && !rx_pop)
        |=> $stable(rx_count_reg) && $stable(rx_wr_ptr_reg))
        else $error("overflow disturbed buffered data");
endmodule : ums_core
`default_nettype wire

/* ums_slave_model.sv */
// Serial slave model: shifts queued bytes out and records what it samples.
// Assumes the bench sets the format and calls prime while the clock idles.
`timescale 1ns/1ns
`default_nettype none
module ums_slave_model (
    input wire logic sck,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb_first,
    input wire logic mosi,
    output logic miso
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] tx_sh = 8'h5a;
    logic [7:0] rx_sh = 8'h00;
    int n = 0;
    task automatic put(input int k);
        miso = lsb_first ? tx_sh[k] : tx_sh[7 - k];
    endtask : put
    task automatic load();
        tx_sh = (tx_q.size() > 0) ? tx_q.pop_front() : 8'h5a;
        put(0);
    endtask : load
    // Phase 1 loads its first byte at the leading edge, so no early pop
    task automatic prime();
        n = 0;
        if (!cpha) load();
    endtask : prime
    initial miso = 1'b0;
    // Sampling edge is the leading one unless phase is set
    always @(sck) begin
        if (((sck !== cpol) ^ cpha) == 1'b1) begin
            rx_sh = lsb_first ? {mosi, rx_sh[7:1]} : {rx_sh[6:0], mosi};
            n++;
            if (n == 8) begin
                rx_q.push_back(rx_sh);
                n = 0;
                // Phase 1 hold has run out: do not keep showing the last bit
                if (cpha) miso = ~miso;
                else load();
            end
        end else if (cpha && n == 0) begin
            load();
        end else begin
            put(n);
        end
    end
endmodule : ums_slave_model
`default_nettype wire

/* ums_core_tb.sv */
// Bench for the master-mode serial port: APB host, slave model, queue scoreboard.
// Assumes the register map and latencies given with the design package.
`timescale 1ns/1ns
`default_nettype none
module ums_core_tb;
    import ums_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic pready, pslverr, rxi, txi, bei, gie = 0, taken = 0, rd_e;
    logic sck, sck_oe, dout, dout_oe, din_own, miso;
    logic cpol = 0, cpha = 0, lsb = 0;
    logic [7:0] exp_tx[$], exp_rx[$], b;
    int errors = 0, check_count = 0, seed = 86;
    always #2 pclk = ~pclk;
    ums_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .global_irq_enable(gie), .tx_complete_irq_taken(taken),
        .rx_complete_irq(rxi), .tx_complete_irq(txi), .buffer_empty_irq(bei),
        .serial_clock_pin(sck), .serial_clock_pin_oe(sck_oe), .serial_data_out_pin(dout),
        .serial_data_out_pin_oe(dout_oe), .serial_data_in_pin(miso),
        .serial_data_in_owned(din_own));
    ums_slave_model slv (.sck(sck), .cpol(cpol), .cpha(cpha), .lsb_first(lsb),
        .mosi(dout), .miso(miso));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 50) begin
            @(posedge pclk);
            t++;
        end
        rd_v = prdata;
        rd_e = pslverr;
        chk({31'h0, pready}, 32'h1, "bus answer");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
        apb(1'b0, a, 32'h0);
        chk(rd_v, e, w);
    endtask : rd
    task automatic wait_st(input int bp);
        int t;
        t = 0;
        apb(1'b0, UMS_ADDR_STATUS, 32'h0);
        while (rd_v[bp] !== 1'b1 && t < 300) begin
            apb(1'b0, UMS_ADDR_STATUS, 32'h0);
            t++;
        end
        chk({31'h0, rd_v[bp]}, 32'h1, "status wait");
    endtask : wait_st
    task automatic xfer(input int nb, input bit rdb, input bit stop);
        for (int i = 0; i < nb; i++) begin
            b = 8'($random(seed));
            slv.tx_q.push_back(b);
            if (i < 2) exp_rx.push_back(b);
        end
        slv.prime();
        for (int i = 0; i < nb; i++) begin
            b = 8'($random(seed));
            exp_tx.push_back(b);
            wait_st(UMS_UDRE_BIT);
            wr(UMS_ADDR_DATA, b);
            if (i == 1) rd(UMS_ADDR_STATUS, 32'h00, "held byte");
        end
        if (stop) begin
            wr(UMS_ADDR_CTRL_B, 8'h00);
            chk(dout_oe, 1'b1, "output kept");
        end
        wait_st(UMS_TXC_BIT);
        repeat (4) @(posedge pclk);
        chk(32'(slv.rx_q.size()), 32'(nb), "frame count");
        while (slv.rx_q.size() > 0) begin
            chk(slv.rx_q.pop_front(), exp_tx.pop_front(), "sent byte");
        end
        chk({sck, dout}, {cpol, 1'b1}, "line idle");
        if (stop) chk({dout_oe, din_own}, 2'h0, "pins released");
        if (rdb) begin
            rd(UMS_ADDR_STATUS, 32'he0, "status full");
            while (exp_rx.size() > 0) begin
                rd(UMS_ADDR_DATA, exp_rx.pop_front(), "received byte");
            end
            rd(UMS_ADDR_STATUS, 32'h60, "status drained");
            wr(UMS_ADDR_STATUS, 8'h40);
            rd(UMS_ADDR_STATUS, 32'h20, "complete cleared");
        end
    endtask : xfer
    initial begin
        #200000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({sck_oe, dout_oe, sck, dout}, 4'h9, "reset pins");
        rd(UMS_ADDR_STATUS, 32'h20, "status reset");
        rd(UMS_ADDR_CTRL_B, 32'h00, "control reset");
        rd(UMS_ADDR_CTRL_C, 32'h06, "format reset");
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, rd_e}, 32'h1, "unmapped error");
        chk(rd_v, 32'h0, "unmapped read");
        chk(pslverr, 1'b0, "error one cycle");
        wr(UMS_ADDR_BAUD, 8'h04);
        $display("reset test done");
        for (int m = 0; m < 8; m++) begin
            {lsb, cpha, cpol} = 3'(m);
            wr(UMS_ADDR_CTRL_C, {UMS_MODE_SPI, 3'h0, lsb, cpha, cpol});
            rd(UMS_ADDR_CTRL_C, {24'h0, UMS_MODE_SPI, 3'h0, lsb, cpha, cpol}, "format");
            wr(UMS_ADDR_CTRL_B, 8'h18);
            repeat (2) @(posedge pclk);
            chk({din_own, dout_oe}, 2'h3, "pins owned");
            xfer(m % 3 + 1, 1'b1, 1'b0);
        end
        $display("format test done");
        gie <= 1'b1;
        wr(UMS_ADDR_CTRL_B, 8'hf8);
        xfer(1, 1'b0, 1'b0);
        chk({rxi, txi, bei}, 3'h7, "irq raised");
        gie <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({rxi, txi, bei}, 3'h0, "irq masked");
        gie <= 1'b1;
        taken <= 1'b1;
        @(posedge pclk);
        taken <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({rxi, txi, bei}, 3'h5, "irq taken");
        wr(UMS_ADDR_CTRL_B, 8'h88);
        rd(UMS_ADDR_STATUS, 32'h20, "rx flushed");
        chk({din_own, rxi}, 2'h0, "rx released");
        exp_rx.delete();
        $display("interrupt test done");
        wr(UMS_ADDR_CTRL_B, 8'h18);
        xfer(2, 1'b0, 1'b1);
        exp_rx.delete();
        wr(UMS_ADDR_STATUS, 8'h40);
        $display("disable test done");
        for (int m = 0; m < 3; m++) begin
            wr(UMS_ADDR_CTRL_C, {2'(m), 6'h06});
            wr(UMS_ADDR_CTRL_B, 8'h18);
            wr(UMS_ADDR_DATA, 8'ha5);
            repeat (80) @(posedge pclk);
            chk(32'(slv.rx_q.size()), 32'h0, "no frame");
            rd(UMS_ADDR_STATUS, 32'h20, "write dropped");
        end
        $display("mode test done");
        complete_run();
    end
endmodule : ums_core_tb
`default_nettype wire
